// ===== rtl/mcu_reset_sequencer.sv
// Reset sequencer: cause tracking, startup delay and register reset values.
// Assumes pin and core strobes synchronous to pclk; presetn is power-on reset.
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none

module mcu_reset_sequencer
	import rst_seq_pkg::*;
(
	input  wire logic        pclk,                // System clock
	input  wire logic        presetn,             // Power-on reset, active low
	input  wire logic        psel,                // APB select
	input  wire logic        penable,             // APB enable
	input  wire logic        pwrite,              // APB direction
	input  wire logic [7:0]  paddr,               // APB byte address
	input  wire logic [31:0] pwdata,              // APB write data
	output logic      [31:0] prdata,              // APB read data
	output logic             pready,              // APB ready
	output logic             pslverr,             // APB error
	input  wire logic        ext_reset_pin_n,     // External reset pin
	input  wire logic        wdt_timeout,         // Watchdog overflow pulse
	input  wire logic        halt_exec,           // Halt instruction pulse
	input  wire logic        clr_wdt_exec,        // Watchdog clear instruction pulse
	input  wire logic        wake_req,            // Interrupt or port wake from halt
	output logic             core_reset_n,        // Core held in reset, active low
	output logic             core_stall,          // Core stalled after wake
	output logic             pc_sp_clear,         // Zero PC, stack pointer to top
	output logic             wdt_clear,           // Watchdog counter cleared
	output logic             wdt_run,             // Watchdog may count
	output logic             timeout_flag,        // Status timeout bit
	output logic             powerdown_flag,      // Status powerdown bit
	output logic      [7:0]  timer_control_reg,   // Timer control
	output logic      [7:0]  interrupt_control_reg, // Interrupt control
	output logic      [7:0]  converter_control_reg, // Converter control
	output logic      [2:0]  converter_clock_select_reg, // Converter clock select
	output logic      [7:0]  port_a_data,         // Port A latch
	output logic      [7:0]  port_a_direction,    // Port A direction, 1 = input
	output logic      [3:0]  port_b_data,         // Port B latch
	output logic      [3:0]  port_b_direction,    // Port B direction
	output logic             port_d_data,         // Port D latch
	output logic             port_d_direction,    // Port D direction
	output logic      [6:0]  memory_pointer,      // Memory pointer
	output logic      [7:0]  table_pointer        // Table pointer
);

	// ****************************************
	// APB decode
	// ****************************************
	seq_state_e  state_reg;
	seq_state_e  state_next;
	logic [10:0] cnt_reg;
	logic [10:0] cnt_next;
	logic        warm_reg;
	logic        to_next;
	logic        pd_next;
	logic [31:0] rd_mux;

	wire setup_rd  = psel && !penable && !pwrite;
	wire wr_go     = psel && penable && pwrite;
	wire hit_cmd   = paddr == OFS_CMD;
	wire mapped    = paddr inside {OFS_STATUS, OFS_CMD, OFS_TMR_CTRL, OFS_INT_CTRL, OFS_CONV_CTRL,
	                              OFS_CONV_CLK, OFS_PORT_A, OFS_PORT_B, OFS_PORT_D, OFS_POINTERS};
	wire sw_halt   = wr_go && hit_cmd && pwdata[CMD_HALT_BIT];
	wire sw_clrwdt = wr_go && hit_cmd && pwdata[CMD_CLRWDT_BIT];
	wire halt_go   = halt_exec || sw_halt;
	wire clr_go    = clr_wdt_exec || sw_clrwdt;
	wire pin_low   = !ext_reset_pin_n;
	wire in_reset  = state_reg == ST_RESET;
	wire ptr_wr    = wr_go && paddr == OFS_POINTERS;

	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;

	always_comb begin
		unique case (paddr)
			OFS_STATUS:    rd_mux = {27'h0, state_reg, warm_reg, powerdown_flag, timeout_flag};
			OFS_TMR_CTRL:  rd_mux = {24'h0, timer_control_reg};
			OFS_INT_CTRL:  rd_mux = {24'h0, interrupt_control_reg};
			OFS_CONV_CTRL: rd_mux = {24'h0, converter_control_reg};
			OFS_CONV_CLK:  rd_mux = {29'h0, converter_clock_select_reg};
			OFS_PORT_A:    rd_mux = {16'h0, port_a_direction, port_a_data};
			OFS_PORT_B:    rd_mux = {24'h0, port_b_direction, port_b_data};
			OFS_PORT_D:    rd_mux = {30'h0, port_d_direction, port_d_data};
			OFS_POINTERS:  rd_mux = {17'h0, memory_pointer, table_pointer};
			default:       rd_mux = 32'h0;
		endcase
	end

	// Read data captured in setup so the access phase needs no wait state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (setup_rd) begin
			prdata <= rd_mux;
		end
	end

	// ****************************************
	// Sequencer
	// ****************************************
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		to_next    = timeout_flag;
		pd_next    = powerdown_flag;
		if (clr_go) begin
			pd_next = 1'b0;
		end
		if (pin_low) begin
			state_next = ST_RESET;
			cnt_next   = 11'h0;
			if (state_reg == ST_HALT || state_reg == ST_WAKE) begin
				to_next = 1'b0;
				pd_next = 1'b1;
			end
		end else begin
			unique case (state_reg)
				ST_RUN: begin
					if (wdt_timeout) begin
						state_next = ST_RESET;
						cnt_next   = 11'h0;
						to_next    = 1'b1;
					end else if (halt_go) begin
						state_next = ST_HALT;
						to_next    = 1'b0;
						pd_next    = 1'b1;
					end
				end
				ST_HALT: begin
					if (wdt_timeout) begin
						state_next = ST_WAKE;
						cnt_next   = 11'h0;
						to_next    = 1'b1;
						pd_next    = 1'b1;
					end else if (wake_req) begin
						state_next = ST_WAKE;
						cnt_next   = 11'h0;
					end
				end
				ST_RESET: begin
					// Startup count then option load, one counter for both
					cnt_next = cnt_reg + 11'h1;
					if (cnt_reg == RESET_LAST) begin
						state_next = ST_RUN;
					end
				end
				ST_WAKE: begin
					cnt_next = cnt_reg + 11'h1;
					if (cnt_reg == STARTUP_LAST) begin
						state_next = ST_RUN;
					end
				end
			endcase
		end
	end

	// Power-on starts in the reset sequence with both cause bits cleared
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg      <= ST_RESET;
			cnt_reg        <= 11'h0;
			timeout_flag   <= 1'b0;
			powerdown_flag <= 1'b0;
			warm_reg       <= 1'b0;
		end else begin
			state_reg      <= state_next;
			cnt_reg        <= cnt_next;
			timeout_flag   <= to_next;
			powerdown_flag <= pd_next;
			warm_reg       <= state_reg == ST_HALT && state_next == ST_WAKE && wdt_timeout;
		end
	end

	assign core_reset_n = !in_reset;
	assign core_stall   = state_reg == ST_WAKE;
	assign pc_sp_clear  = in_reset || warm_reg;
	assign wdt_clear    = in_reset;
	assign wdt_run      = state_reg == ST_RUN || state_reg == ST_HALT;

	// ****************************************
	// Reset-loaded registers
	// ****************************************
	// Held at defaults for the whole reset so software cannot race the load
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_control_reg          <= TMR_CTRL_RST;
			interrupt_control_reg      <= INT_CTRL_RST;
			converter_control_reg      <= CONV_CTRL_RST;
			converter_clock_select_reg <= CONV_CLK_RST;
			{port_a_data, port_a_direction} <= {PORT_A_RST, PORT_A_RST};
			{port_b_data, port_b_direction} <= {PORT_B_RST, PORT_B_RST};
			{port_d_data, port_d_direction} <= {PORT_D_RST, PORT_D_RST};
		end else if (in_reset) begin
			timer_control_reg          <= TMR_CTRL_RST;
			interrupt_control_reg      <= INT_CTRL_RST;
			converter_control_reg      <= CONV_CTRL_RST;
			converter_clock_select_reg <= CONV_CLK_RST;
			{port_a_data, port_a_direction} <= {PORT_A_RST, PORT_A_RST};
			{port_b_data, port_b_direction} <= {PORT_B_RST, PORT_B_RST};
			{port_d_data, port_d_direction} <= {PORT_D_RST, PORT_D_RST};
		end else if (wr_go) begin
			unique case (paddr)
				OFS_TMR_CTRL:  timer_control_reg          <= pwdata[7:0] & TMR_CTRL_MASK;
				OFS_INT_CTRL:  interrupt_control_reg      <= pwdata[7:0] & INT_CTRL_MASK;
				OFS_CONV_CTRL: converter_control_reg      <= pwdata[7:0];
				OFS_CONV_CLK:  converter_clock_select_reg <= pwdata[2:0];
				OFS_PORT_A:    {port_a_direction, port_a_data} <= pwdata[15:0];
				OFS_PORT_B:    {port_b_direction, port_b_data} <= pwdata[7:0];
				OFS_PORT_D:    {port_d_direction, port_d_data} <= pwdata[1:0];
				default: ;
			endcase
		end
	end

	// Pointers are not touched by any sequenced reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{memory_pointer, table_pointer} <= 15'h0;
		end else if (ptr_wr) begin
			{memory_pointer, table_pointer} <= pwdata[14:0];
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	pin_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
		pin_low |=> !core_reset_n && wdt_clear)
		else $error("pin low did not enter reset");

	warm_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == ST_HALT && wdt_timeout && !pin_low) |=>
		core_reset_n && pc_sp_clear && $stable(port_a_direction) && $stable(timer_control_reg))
		else $error("warm reset disturbed registers");

	wdt_halt_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == ST_HALT && wdt_timeout && !pin_low) |=> timeout_flag && powerdown_flag)
		else $error("warm reset cause bits not 11");

	pin_halt_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == ST_HALT && pin_low) |=> !timeout_flag && powerdown_flag)
		else $error("pin wake cause bits not 01");

	wdt_run_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == ST_RUN && wdt_timeout && !pin_low) |=> timeout_flag ##1 !core_reset_n)
		else $error("watchdog run cause bit not set");

	wake_delay_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == ST_HALT && wake_req && !wdt_timeout && !pin_low) |=>
		core_stall && cnt_reg == 11'h0)
		else $error("wake did not start startup delay");

	option_delay_a: assert property (@(posedge pclk) disable iff (!presetn)
		(in_reset && cnt_reg == STARTUP_LAST && !pin_low) |=> !core_reset_n [*8])
		else $error("option load delay missing");

	reset_values_a: assert property (@(posedge pclk) disable iff (!presetn)
		(in_reset && $past(in_reset)) |-> timer_control_reg == TMR_CTRL_RST &&
		converter_control_reg == CONV_CTRL_RST && converter_clock_select_reg == CONV_CLK_RST)
		else $error("reset values not loaded");

	port_values_a: assert property (@(posedge pclk) disable iff (!presetn)
		(in_reset && $past(in_reset)) |-> &{port_a_data, port_a_direction, port_b_data,
		port_b_direction, port_d_data, port_d_direction})
		else $error("ports not set to input");

	halt_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == ST_RUN && halt_go && !wdt_timeout && !pin_low) |=>
		powerdown_flag && !timeout_flag && wdt_run)
		else $error("halt flags wrong");

	// ****************************************
	// Assertions: counter end points and holds
	// ****************************************
	// An off-by-one at RESET_LAST shifts every release from reset, at STARTUP_LAST every end of a wake stall
	wdt_release_a: assert property (@(posedge pclk) disable iff (!presetn)
		(in_reset && cnt_reg == RESET_LAST && !pin_low) |=> core_reset_n && wdt_run && !wdt_clear)
		else $error("watchdog not released after reset");

	int_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
		(in_reset && $past(in_reset)) |-> interrupt_control_reg == INT_CTRL_RST && pc_sp_clear)
		else $error("interrupts or PC not reset");

	warm_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == ST_HALT && wdt_timeout && !pin_low) |=> pc_sp_clear ##1 (in_reset || !pc_sp_clear))
		else $error("warm stack clear not one cycle");

	wake_end_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == ST_WAKE && cnt_reg == STARTUP_LAST && !pin_low) |=> !core_stall && wdt_run)
		else $error("wake delay did not end on count");

	pin_run_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == ST_RUN && pin_low && !clr_go) |=> $stable(timeout_flag) && $stable(powerdown_flag))
		else $error("pin reset while running changed cause bits");

	clr_pd_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == ST_RUN && clr_go && !halt_go && !wdt_timeout && !pin_low) |=> !powerdown_flag)
		else $error("watchdog clear kept powerdown");

	pointer_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
		!ptr_wr |=> $stable({memory_pointer, table_pointer}))
		else $error("pointers changed without a write");

endmodule // mcu_reset_sequencer

`default_nettype wire

// ===== include/rst_seq_pkg.sv
// Constants, register map and reset values for the reset sequencer.
// Assumes a 100 MHz pclk and a 32-bit APB master.
package rst_seq_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int unsigned CLK_PERIOD_NS   = 10;
	localparam int unsigned STARTUP_CLOCKS  = 1024;
	localparam int unsigned OPT_LOAD_CLOCKS = 16;
	localparam logic [10:0] STARTUP_LAST    = 11'(STARTUP_CLOCKS - 1);
	localparam logic [10:0] RESET_LAST      = 11'(STARTUP_CLOCKS + OPT_LOAD_CLOCKS - 1);

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] OFS_STATUS    = 8'h00;
	localparam logic [7:0] OFS_CMD       = 8'h04;
	localparam logic [7:0] OFS_TMR_CTRL  = 8'h08;
	localparam logic [7:0] OFS_INT_CTRL  = 8'h0C;
	localparam logic [7:0] OFS_CONV_CTRL = 8'h10;
	localparam logic [7:0] OFS_CONV_CLK  = 8'h14;
	localparam logic [7:0] OFS_PORT_A    = 8'h18;
	localparam logic [7:0] OFS_PORT_B    = 8'h1C;
	localparam logic [7:0] OFS_PORT_D    = 8'h20;
	localparam logic [7:0] OFS_POINTERS  = 8'h24;

	// ****************************************
	// Fields, masks and reset values
	// ****************************************
	localparam int unsigned CMD_HALT_BIT   = 0;
	localparam int unsigned CMD_CLRWDT_BIT = 1;
	localparam logic [7:0]  TMR_CTRL_RST   = 8'h08;
	localparam logic [7:0]  TMR_CTRL_MASK  = 8'hDF;
	localparam logic [7:0]  INT_CTRL_RST   = 8'h00;
	localparam logic [7:0]  INT_CTRL_MASK  = 8'h7F;
	localparam logic [7:0]  CONV_CTRL_RST  = 8'h40;
	localparam logic [2:0]  CONV_CLK_RST   = 3'h4;
	localparam logic [7:0]  PORT_A_RST     = 8'hFF;
	localparam logic [3:0]  PORT_B_RST     = 4'hF;
	localparam logic        PORT_D_RST     = 1'b1;

	typedef enum logic [1:0] {
		ST_RUN   = 2'b00,
		ST_HALT  = 2'b01,
		ST_RESET = 2'b10,
		ST_WAKE  = 2'b11
	} seq_state_e;

endpackage

// ===== tb/reset_pin_model.sv
// Model of the external reset circuit that drives the reset pin.
// Assumes presses are requested by the bench and are synchronous to pclk.
`timescale 1ns/1ns
`default_nettype none

module reset_pin_model (
	input  wire logic       pclk,  // System clock
	input  wire logic       hit,   // Start a press
	input  wire logic [7:0] len,   // Press length in cycles
	output logic            pin_n  // Reset pin, pulled high when idle
);
	logic [7:0] left_reg = 8'h00;

	// Pull-up holds the pin high whenever no press is running
	always @(posedge pclk) begin
		if (hit)
			left_reg <= len;
		else if (left_reg != 8'h00)
			left_reg <= left_reg - 8'h01;
	end
	assign pin_n = (left_reg == 8'h00);
endmodule // reset_pin_model

`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the reset sequencer: causes, delays, reset values.
// Assumes the sequencer package is compiled first and the pin model beside it.
`timescale 1ns/1ns
`default_nettype none

module testbench
	import rst_seq_pkg::*;
;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, len, timer_control_reg, interrupt_control_reg, converter_control_reg;
	logic [7:0]  port_a_data, port_a_direction, table_pointer;
	logic [31:0] pwdata, prdata;
	logic        ext_reset_pin_n, wdt_timeout, halt_exec, clr_wdt_exec, wake_req, hit, err_seen;
	logic        core_reset_n, core_stall, pc_sp_clear, wdt_clear, wdt_run, timeout_flag, powerdown_flag;
	logic [2:0]  converter_clock_select_reg;
	logic [3:0]  port_b_data, port_b_direction;
	logic        port_d_data, port_d_direction;
	logic [6:0]  memory_pointer;
	int          err_total, total_checks, cyc, n;
	logic [7:0]  addrs [7] = '{OFS_TMR_CTRL, OFS_INT_CTRL, OFS_CONV_CTRL, OFS_CONV_CLK, OFS_PORT_A, OFS_PORT_B, OFS_PORT_D};
	logic [31:0] rstv [7] = '{{24'h0, TMR_CTRL_RST}, {24'h0, INT_CTRL_RST}, {24'h0, CONV_CTRL_RST},
		{29'h0, CONV_CLK_RST}, {16'h0, PORT_A_RST, PORT_A_RST}, {24'h0, PORT_B_RST, PORT_B_RST},
		{30'h0, PORT_D_RST, PORT_D_RST}};
	logic [31:0] dirt [7] = '{32'h11, 32'h55, 32'h12, 32'h1, 32'h0, 32'h0, 32'h0};
	localparam logic [31:0] PORT_EXP = {6'h0, PORT_A_RST, PORT_A_RST, PORT_B_RST, PORT_B_RST, PORT_D_RST, PORT_D_RST};
	localparam logic [31:0] CTRL_EXP = {5'h0, TMR_CTRL_RST, INT_CTRL_RST, CONV_CTRL_RST, CONV_CLK_RST};
	wire         [31:0] port_outs = {6'h0, port_a_data, port_a_direction, port_b_data, port_b_direction,
		port_d_data, port_d_direction};
	wire         [31:0] ctrl_outs = {5'h0, timer_control_reg, interrupt_control_reg, converter_control_reg,
		converter_clock_select_reg};

	mcu_reset_sequencer u_mcu_reset_sequencer (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .ext_reset_pin_n, .wdt_timeout, .halt_exec, .clr_wdt_exec, .wake_req,
		.core_reset_n, .core_stall, .pc_sp_clear, .wdt_clear, .wdt_run, .timeout_flag, .powerdown_flag,
		.timer_control_reg, .interrupt_control_reg, .converter_control_reg, .converter_clock_select_reg,
		.port_a_data, .port_a_direction, .port_b_data, .port_b_direction, .port_d_data, .port_d_direction,
		.memory_pointer, .table_pointer);
	reset_pin_model u_reset_pin_model (.pclk(pclk), .hit(hit), .len(len), .pin_n(ext_reset_pin_n));

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic final_report;
		if (err_total == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Request held until pready is sampled high; data and error taken at that edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		err_seen = pslverr;
		{psel, penable} <= 2'b00;
	endtask

	task automatic regs(input logic wr, input logic dirty);
		logic [31:0] q;
		for (int i = 0; i < 7; i++) begin
			apb(wr, addrs[i], dirt[i], q);
			if (!wr)
				chk("register", dirty ? dirt[i] : rstv[i], q);
		end
	endtask

	task automatic pulse(input int k);
		@(posedge pclk);
		case (k)
			0: halt_exec <= 1'b1;
			1: wake_req <= 1'b1;
			2: wdt_timeout <= 1'b1;
			default: clr_wdt_exec <= 1'b1;
		endcase
		@(posedge pclk);
		{halt_exec, wake_req, wdt_timeout, clr_wdt_exec} <= 4'h0;
		#1;
	endtask

	task automatic count_until(input logic stall);
		n = 0;
		do begin
			@(posedge pclk);
			#1;
			n++;
		end while ((stall ? core_stall : !core_reset_n) !== 1'b0);
	endtask

	task automatic press;
		@(posedge pclk);
		{hit, len} <= {1'b1, 8'd5};
		@(posedge pclk);
		hit <= 1'b0;
		@(posedge ext_reset_pin_n);
		#1;
		chk("core_reset_n", 0, core_reset_n);
		chk("wdt_clear", 1, wdt_clear);
		chk("pc_sp_clear", 1, pc_sp_clear);
		count_until(1'b0);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_power_on;
		logic [31:0] q;
		count_until(1'b0);
		chk("startup", STARTUP_CLOCKS + OPT_LOAD_CLOCKS, n);
		chk("wdt_run", 1, wdt_run);
		chk("port outputs", PORT_EXP, port_outs);
		chk("control outputs", CTRL_EXP, ctrl_outs);
		regs(1'b0, 1'b0);
		apb(1'b0, OFS_STATUS, 32'h0, q);
		chk("status", 32'h0, q);
		apb(1'b0, 8'h30, 32'h0, q);
		chk("unmapped", 1, err_seen);
		apb(1'b1, OFS_POINTERS, 32'h1234, q);
	endtask

	task automatic t_wdt_then_pin;
		regs(1'b1, 1'b0);
		pulse(2);
		count_until(1'b0);
		chk("wdt startup", STARTUP_CLOCKS + OPT_LOAD_CLOCKS, n);
		chk("wdt flags", 2'b01, {powerdown_flag, timeout_flag});
		regs(1'b0, 1'b0);
		regs(1'b1, 1'b0);
		press();
		chk("pin startup", STARTUP_CLOCKS + OPT_LOAD_CLOCKS, n);
		chk("pin flags", 2'b01, {powerdown_flag, timeout_flag});
		regs(1'b0, 1'b0);
		chk("pointers", 32'h1234, {17'h0, memory_pointer, table_pointer});
	endtask

	task automatic t_halt_wake;
		logic [31:0] q;
		regs(1'b1, 1'b0);
		pulse(0);
		chk("halt flags", 2'b10, {powerdown_flag, timeout_flag});
		pulse(1);
		count_until(1'b1);
		chk("wake stall", STARTUP_CLOCKS, n);
		apb(1'b1, OFS_CMD, 32'h1, q);
		pulse(2);
		chk("warm clear", 3'b111, {pc_sp_clear, core_reset_n, core_stall});
		chk("warm flags", 2'b11, {powerdown_flag, timeout_flag});
		count_until(1'b1);
		chk("warm stall", STARTUP_CLOCKS, n);
		regs(1'b0, 1'b1);
		apb(1'b0, OFS_STATUS, 32'h0, q);
		chk("status", 32'h3, q);
	endtask

	task automatic t_pin_halt;
		logic [31:0] q;
		apb(1'b1, OFS_CMD, 32'h1, q);
		press();
		chk("halt pin flags", 2'b10, {powerdown_flag, timeout_flag});
		chk("pc_sp_clear", 0, pc_sp_clear);
		regs(1'b0, 1'b0);
		pulse(3);
		chk("clear flags", 2'b00, {powerdown_flag, timeout_flag});
	endtask

	// Power-on while halted must drop powerdown and the pointers as well
	task automatic t_power_cycle;
		logic [31:0] q;
		pulse(0);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		count_until(1'b0);
		chk("repower startup", STARTUP_CLOCKS + OPT_LOAD_CLOCKS, n);
		chk("repower flags", 2'b00, {powerdown_flag, timeout_flag});
		chk("repower pointers", 0, {memory_pointer, table_pointer});
		chk("repower ports", PORT_EXP, port_outs);
		apb(1'b0, OFS_STATUS, 32'h0, q);
		chk("repower status", 32'h0, q);
	endtask

	// ****************************************
	// Clock, reset, sequence, timeout
	// ****************************************
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 30000) begin
			err_total++;
			final_report();
		end
	end

	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, hit, len} = '0;
		{wdt_timeout, halt_exec, clr_wdt_exec, wake_req} = 4'h0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_power_on();
		t_wdt_then_pin();
		t_halt_wake();
		t_pin_halt();
		t_power_cycle();
		final_report();
	end
endmodule // testbench

`default_nettype wire
